// >>> fsc_flash_ctrl.sv
/*
   serial flash receive engine with mosi fill control, state reporting,
   flash supply switch and controller bypass, behind an apb slave.
   assumes: flashSck and flashChipSelectN come from outside and are slow
   against ref_clk (several ref_clk cycles per half period); received
   bytes leave through a valid/ready stream buffered by a 16-byte fifo.

*/
// Our own choice: the APB register port.
`timescale 1ns/1ns
module fsc_flash_ctrl (
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic [31:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        flashSck,
   input  wire logic        flashChipSelectN,
   input  wire logic        flashMiso,
   output logic             flashMosi,
   output logic             flashIoSupplyEn,
   output logic             controllerBypass,
   output logic      [7:0]  rxData,
   output logic             rxValid,
   input  wire logic        rxReady
);

   // ==========================================================
   // helpers

   // true for any of the four mapped word addresses
   function automatic logic isMapped(input logic [31:0] a);
      return (a == fsc_pkg::ADDR_SUPPLY) || (a == fsc_pkg::ADDR_BYPASS) ||
             (a == fsc_pkg::ADDR_FILL) || (a == fsc_pkg::ADDR_STATE);
   endfunction : isMapped

   // mosi level for bit idx of a byte, fixed priority order
   function automatic logic fillBit(input logic [15:0] cfg, input logic [2:0] idx);
      logic [7:0] dummy;
      dummy = cfg[fsc_pkg::FILL_BYTE_LSB +: 8];
      if (cfg[fsc_pkg::FILL_DUMMY_POS]) begin
         return dummy[fsc_pkg::LAST_BIT - idx];
      end else if (cfg[fsc_pkg::FILL_TOG_POS]) begin
         return ~idx[0];
      end else if (cfg[fsc_pkg::FILL_HIGH_POS]) begin
         return 1'b1;
      end else begin
         return 1'b0;
      end
   endfunction : fillBit

   // ==========================================================
   // declarations
   logic [7:0]         supply_q;
   logic [7:0]         supply_d;
   logic [7:0]         bypass_q;
   logic [7:0]         bypass_d;
   logic [15:0]        fill_q;
   logic [15:0]        fill_d;
   logic [31:0]        prdata_q;
   logic [31:0]        prdata_d;
   logic [15:0]        stateWord;
   logic [2:0]         linkSync;
   logic               sckS;
   logic               csnS;
   logic               misoS;
   logic               sckPrev_q;
   logic               sckRise;
   logic               sckFall;
   logic               active;
   fsc_pkg::fsc_ser_e  serState_q;
   fsc_pkg::fsc_ser_e  serState_d;
   logic [2:0]         bitCnt_q;
   logic [2:0]         bitCnt_d;
   logic [7:0]         shift_q;
   logic [7:0]         shift_d;
   logic [7:0]         byte_q;
   logic [7:0]         byte_d;
   logic               mosi_q;
   logic               mosi_d;
   logic               pushValid;
   logic               pushReady;
   fsc_pkg::fsc_fifo_e fifoState_q;
   fsc_pkg::fsc_fifo_e fifoState_d;
   fsc_pkg::fsc_bus_e  busState_q;
   fsc_pkg::fsc_bus_e  busState_d;
   logic               apbWrite;
   logic               apbSetupRd;

   // ==========================================================
   // link inputs: synchronise, then find clock edges
   fsc_sync #(
      .W (3)
   ) u_sync (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .asyncIn ({flashSck, flashChipSelectN, flashMiso}),
      .syncOut (linkSync)
   );

   assign sckS    = linkSync[2];
   assign csnS    = linkSync[1];
   assign misoS   = linkSync[0];
   assign sckRise = sckS && !sckPrev_q;
   assign sckFall = !sckS && sckPrev_q;
   assign active  = !csnS && !bypass_q[0];

   // ==========================================================
   // apb slave: zero wait states, error on unmapped or read-only write
   assign apbWrite   = psel && penable && pwrite;
   assign apbSetupRd = psel && !penable && !pwrite;
   assign pready     = 1'b1;
   assign pslverr    = psel && penable && (!isMapped(paddr) || (pwrite && paddr == fsc_pkg::ADDR_STATE));
   assign prdata     = prdata_q;

   // state register image
   always_comb begin
      stateWord = '0;
      stateWord[fsc_pkg::ST_CS_POS] = csnS;
      stateWord[fsc_pkg::ST_SER_LSB +: 3] = serState_q;
      stateWord[fsc_pkg::ST_FIFO_LSB +: 3] = fifoState_q;
      stateWord[fsc_pkg::ST_BUS_LSB +: 2] = busState_q;
   end

   // register writes in the access phase, read data capture in the setup phase
   always_comb begin
      supply_d = supply_q;
      bypass_d = bypass_q;
      fill_d   = fill_q;
      prdata_d = prdata_q;
      if (apbWrite && paddr == fsc_pkg::ADDR_SUPPLY) begin
         supply_d = pwdata[7:0] & fsc_pkg::BIT0_MASK;
      end
      if (apbWrite && paddr == fsc_pkg::ADDR_BYPASS) begin
         bypass_d = pwdata[7:0] & fsc_pkg::BIT0_MASK;
      end
      if (apbWrite && paddr == fsc_pkg::ADDR_FILL) begin
         fill_d = pwdata[15:0] & fsc_pkg::FILL_MASK;
      end
      if (apbSetupRd) begin
         case (paddr)
            fsc_pkg::ADDR_SUPPLY: prdata_d = {24'h000000, supply_q};
            fsc_pkg::ADDR_BYPASS: prdata_d = {24'h000000, bypass_q};
            fsc_pkg::ADDR_FILL:   prdata_d = {16'h0000, fill_q};
            fsc_pkg::ADDR_STATE:  prdata_d = {16'h0000, stateWord};
            default:              prdata_d = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         supply_q <= fsc_pkg::SUPPLY_RST;
         bypass_q <= fsc_pkg::BYPASS_RST;
         fill_q   <= fsc_pkg::FILL_RST;
         prdata_q <= '0;
      end else begin
         supply_q <= supply_d;
         bypass_q <= bypass_d;
         fill_q   <= fill_d;
         prdata_q <= prdata_d;
      end
   end

   assign flashIoSupplyEn  = supply_q[0];
   assign controllerBypass = bypass_q[0];

   // ==========================================================
   // serial engine: sample miso on rise, launch fill bit on fall
   always_comb begin
      serState_d = serState_q;
      bitCnt_d   = bitCnt_q;
      shift_d    = shift_q;
      byte_d     = byte_q;
      mosi_d     = 1'b0;
      pushValid  = 1'b0;
      if (active) begin
         mosi_d = mosi_q;
         if (sckFall) begin
            mosi_d = fillBit(fill_q, bitCnt_q);
         end
      end
      case (serState_q)
         fsc_pkg::SER_IDLE: begin
            if (active) begin
               serState_d = fsc_pkg::SER_SHIFT;
               bitCnt_d   = '0;
               mosi_d     = fillBit(fill_q, 3'h0);
            end
         end
         fsc_pkg::SER_SHIFT: begin
            if (!active) begin
               serState_d = fsc_pkg::SER_IDLE;
            end else if (sckRise) begin
               shift_d  = {shift_q[6:0], misoS};
               bitCnt_d = bitCnt_q + 3'h1;
               if (bitCnt_q == fsc_pkg::LAST_BIT) begin
                  byte_d     = {shift_q[6:0], misoS};
                  serState_d = fsc_pkg::SER_PUSH;
               end
            end
         end
         fsc_pkg::SER_PUSH: begin
            pushValid = !bypass_q[0];
            if (bypass_q[0]) begin
               serState_d = fsc_pkg::SER_IDLE;
            end else if (pushReady) begin
               serState_d = active ? fsc_pkg::SER_SHIFT : fsc_pkg::SER_IDLE;
            end
         end
         default: begin
            serState_d = fsc_pkg::SER_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         serState_q <= fsc_pkg::SER_IDLE;
         bitCnt_q   <= '0;
         shift_q    <= '0;
         byte_q     <= '0;
         mosi_q     <= 1'b0;
         sckPrev_q  <= 1'b0;
      end else begin
         serState_q <= serState_d;
         bitCnt_q   <= bitCnt_d;
         shift_q    <= shift_d;
         byte_q     <= byte_d;
         mosi_q     <= mosi_d;
         sckPrev_q  <= sckS;
      end
   end

   assign flashMosi = mosi_q;

   // ==========================================================
   // receive buffer towards the system side
   fsc_fifo #(
      .W     (fsc_pkg::DATA_W),
      .DEPTH (fsc_pkg::FIFO_DEPTH)
   ) u_fifo (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .inData   (byte_q),
      .inValid  (pushValid),
      .inReady  (pushReady),
      .outData  (rxData),
      .outValid (rxValid),
      .outReady (rxReady)
   );

   // fifo control and bus master state tracking
   always_comb begin
      if (!pushReady) begin
         fifoState_d = fsc_pkg::FC_FULL;
      end else if (rxValid) begin
         fifoState_d = fsc_pkg::FC_PART;
      end else begin
         fifoState_d = fsc_pkg::FC_EMPTY;
      end
      case (busState_q)
         fsc_pkg::BM_IDLE:  busState_d = rxValid ? fsc_pkg::BM_OFFER : fsc_pkg::BM_IDLE;
         fsc_pkg::BM_OFFER: busState_d = (rxReady && !rxValid) ? fsc_pkg::BM_IDLE : fsc_pkg::BM_OFFER;
         default:           busState_d = fsc_pkg::BM_IDLE;
      endcase
      if (!rxValid) begin
         busState_d = fsc_pkg::BM_IDLE;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         fifoState_q <= fsc_pkg::FC_EMPTY;
         busState_q  <= fsc_pkg::BM_IDLE;
      end else begin
         fifoState_q <= fifoState_d;
         busState_q  <= busState_d;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   dummy_fill_a: assert property ((active && sckFall && fill_q[3]) |=> flashMosi == $past(fill_q[15 - bitCnt_q]))
      else $error("dummy fill bit wrong");
   dummy_first_a: assert property ((serState_q == fsc_pkg::SER_IDLE && active && fill_q[3]) |=> flashMosi == $past(fill_q[15]))
      else $error("first dummy bit wrong");
   toggle_fill_a: assert property ((active && sckFall && fill_q[3:2] == 2'b01) |=> flashMosi == !$past(bitCnt_q[0]))
      else $error("toggle fill wrong");
   high_fill_a: assert property ((active && sckFall && fill_q[3:1] == 3'b001) |=> flashMosi)
      else $error("mosi not high");
   low_fill_a: assert property ((active && sckFall && fill_q[3:0] == 4'b0001) |=> !flashMosi)
      else $error("mosi not low");
   fill_prio_a: assert property ((active && sckFall && fill_q[3] && fill_q[2]) |=> flashMosi == $past(fill_q[15 - bitCnt_q]))
      else $error("fill priority wrong");
   cs_status_a: assert property (($stable(flashChipSelectN)[*4] ##0 apbSetupRd && paddr == fsc_pkg::ADDR_STATE)
      |=> prdata[12] == $past(flashChipSelectN))
      else $error("chip select status wrong");
   ser_status_a: assert property ((apbSetupRd && paddr == fsc_pkg::ADDR_STATE) |=> prdata[10:8] == $past(serState_q))
      else $error("serial state wrong");
   fifo_status_a: assert property ((apbSetupRd && paddr == fsc_pkg::ADDR_STATE && !$past(pushReady))
      |=> prdata[6:4] == 3'b010)
      else $error("fifo state wrong");
   bus_status_a: assert property ((apbSetupRd && paddr == fsc_pkg::ADDR_STATE) |=> prdata[1:0] == $past(busState_q))
      else $error("bus state wrong");
   supply_ctl_a: assert property ((apbWrite && paddr == fsc_pkg::ADDR_SUPPLY) |=> flashIoSupplyEn == $past(pwdata[0]))
      else $error("supply enable wrong");
   bypass_idle_a: assert property (controllerBypass |=> serState_q == fsc_pkg::SER_IDLE && !pushValid)
      else $error("engine runs in bypass");

endmodule : fsc_flash_ctrl

// >>> fsc_pkg.sv
/*
   constants, field layout, reset values and state encodings of the serial
   flash fill/status/power register block.
   assumes: nothing beyond a SystemVerilog compiler.
*/
package fsc_pkg;

   // ==========================================================
   // register byte addresses on the apb bus
   localparam logic [31:0] ADDR_SUPPLY = 32'h4000b0a0;
   localparam logic [31:0] ADDR_BYPASS = 32'h4000b0a4;
   localparam logic [31:0] ADDR_FILL   = 32'h40012024;
   localparam logic [31:0] ADDR_STATE  = 32'h40012028;

   // ==========================================================
   // reset values and writable-bit masks
   localparam logic [7:0]  SUPPLY_RST  = 8'h01;
   localparam logic [7:0]  BYPASS_RST  = 8'h00;
   localparam logic [15:0] FILL_RST    = 16'h0000;
   localparam logic [7:0]  BIT0_MASK   = 8'h01;
   localparam logic [15:0] FILL_MASK   = 16'hff0f;

   // ==========================================================
   // field positions
   localparam int FILL_LOW_POS   = 0;
   localparam int FILL_HIGH_POS  = 1;
   localparam int FILL_TOG_POS   = 2;
   localparam int FILL_DUMMY_POS = 3;
   localparam int FILL_BYTE_LSB  = 8;
   localparam int ST_BUS_LSB     = 0;
   localparam int ST_FIFO_LSB    = 4;
   localparam int ST_SER_LSB     = 8;
   localparam int ST_CS_POS      = 12;

   // ==========================================================
   // data path sizes and counts
   localparam int          DATA_W    = 8;
   localparam int          FIFO_DEPTH = 16;
   localparam logic [2:0]  LAST_BIT  = 3'h7;

   // ==========================================================
   // state encodings shown in the state register
   typedef enum logic [2:0] {
      SER_IDLE  = 3'b000,
      SER_SHIFT = 3'b001,
      SER_PUSH  = 3'b010
   } fsc_ser_e;

   typedef enum logic [2:0] {
      FC_EMPTY = 3'b000,
      FC_PART  = 3'b001,
      FC_FULL  = 3'b010
   } fsc_fifo_e;

   typedef enum logic [1:0] {
      BM_IDLE  = 2'b00,
      BM_OFFER = 2'b01
   } fsc_bus_e;

endpackage : fsc_pkg

// >>> fsc_sync.sv
/*
   two flip-flop synchroniser for a group of level inputs.
   assumes: inputs are asynchronous to ref_clk; only stage two is read.
*/
`timescale 1ns/1ns
module fsc_sync #(
   parameter int W = 1
) (
   input  wire logic         ref_clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] asyncIn,
   output logic      [W-1:0] syncOut
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // ==========================================================
   // two stages, the first read only by the second
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= asyncIn;
         sync_q <= meta_q;
      end
   end

   assign syncOut = sync_q;

endmodule : fsc_sync

// >>> fsc_fifo.sv
/*
   byte fifo with valid/ready on both sides.
   assumes: single clock ref_clk, synchronous active-high reset; DEPTH a power of two.
*/
`timescale 1ns/1ns
module fsc_fifo #(
   parameter int W     = fsc_pkg::DATA_W,
   parameter int DEPTH = fsc_pkg::FIFO_DEPTH
) (
   input  wire logic         ref_clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] inData,
   input  wire logic         inValid,
   output logic              inReady,
   output logic      [W-1:0] outData,
   output logic              outValid,
   input  wire logic         outReady
);

   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem_q [DEPTH];
   logic [AW:0]  wrPtr_q;
   logic [AW:0]  wrPtr_d;
   logic [AW:0]  rdPtr_q;
   logic [AW:0]  rdPtr_d;
   logic         push;
   logic         pop;

   // ==========================================================
   // flags: full when pointers differ only in the wrap bit
   assign inReady  = !((wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]));
   assign outValid = (wrPtr_q != rdPtr_q);
   assign outData  = mem_q[rdPtr_q[AW-1:0]];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   // next pointer values
   always_comb begin
      wrPtr_d = wrPtr_q + {{AW{1'b0}}, push};
      rdPtr_d = rdPtr_q + {{AW{1'b0}}, pop};
   end

   // pointer registers
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
      end else begin
         wrPtr_q <= wrPtr_d;
         rdPtr_q <= rdPtr_d;
      end
   end

   // storage, written on push
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_q[wrPtr_q[AW-1:0]] <= inData;
      end
   end

endmodule : fsc_fifo

// >>> fsc_flash_model.sv
/*
   behavioural stacked serial flash for the bench: makes the link clock,
   chip select and miso, and captures what the controller puts on mosi.
   assumes: sck idles low, data changes after the falling edge, 800 ns period.
*/
`timescale 1ns/1ns
module fsc_flash_model (
   output logic     flashSck,
   output logic     flashChipSelectN,
   output logic     flashMiso,
   input  wire logic flashMosi
);
   // ==========================================================
   // idle levels: link clock stands still outside frames
   initial begin
      flashSck         = 1'b0;
      flashChipSelectN = 1'b1;
      flashMiso        = 1'b0;
   end

   // ==========================================================
   // frame start and end; odd delays keep pin edges off ref_clk edges
   task automatic frame_edge(input logic start);
      if (start) begin
         #13 flashChipSelectN = !start; // off the ref_clk edge
         #1024;
      end else begin
         #400;
         flashChipSelectN = !start;
         flashMiso        = ~flashMiso; // released line must not keep its last value
         #837;
      end
   endtask : frame_edge

   // one byte msb first; mosi taken late in the high half, well after it settled
   task automatic send_byte(input logic [7:0] misoByte, output logic [7:0] mosiByte);
      for (int i = 7; i >= 0; i--) begin
         flashMiso = misoByte[i];
         #400 flashSck = 1'b1;
         #360 mosiByte[i] = flashMosi;
         #40 flashSck = 1'b0;
      end
   endtask : send_byte
endmodule : fsc_flash_model

// >>> tb_serial_flash_txfill_status_power.sv
/*
   self-checking bench for the fill/status/power block: apb register traffic,
   fill patterns on mosi, the receive fifo and the bypass switch.
   assumes: fsc_pkg compiled first; fsc_flash_model stands on the link side.
*/
`timescale 1ns/1ns
`define CHK(got, exp) begin numChecks++; if ((got) !== (exp)) begin nMismatch++; \
   $display("Error at %0t: value %h expected %h", $time, (got), (exp)); end end

module tb_serial_flash_txfill_status_power;
   typedef struct packed {logic [15:0] fill; logic [7:0] miso; logic [7:0] mosi;} fsc_row_s;
   // fill setting, byte the flash sends, byte expected on mosi
   localparam fsc_row_s ROWS [8] = '{'{16'h0001, 8'h5a, 8'h00}, '{16'h0002, 8'ha5, 8'hff},
      '{16'h0004, 8'h3c, 8'haa}, '{16'h3c08, 8'hc3, 8'h3c}, '{16'h81fd, 8'h01, 8'h81},
      '{16'h0007, 8'h80, 8'haa}, '{16'h0003, 8'h7e, 8'hff}, '{16'h0000, 8'hff, 8'h00}};
   logic        ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic        flashSck, flashChipSelectN, flashMiso, flashMosi;
   logic        flashIoSupplyEn, controllerBypass, rxValid, rxReady;
   logic [7:0]  rxData, mo;
   int          nMismatch, numChecks;

   fsc_flash_ctrl dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .flashSck(flashSck), .flashChipSelectN(flashChipSelectN),
      .flashMiso(flashMiso), .flashMosi(flashMosi), .flashIoSupplyEn(flashIoSupplyEn),
      .controllerBypass(controllerBypass), .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady));
   fsc_flash_model fm (.flashSck(flashSck), .flashChipSelectN(flashChipSelectN),
      .flashMiso(flashMiso), .flashMosi(flashMosi));

   // ==========================================================
   // 10 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // verdict and end of run
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", numChecks, nMismatch);
      if (nMismatch == 0 && numChecks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict

   // one apb transfer; read data and error land in rd and err
   task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d);
      int k;
      @(posedge ref_clk);
      paddr  <= a;
      pwrite <= w;
      pwdata <= d;
      psel   <= 1'b1;
      @(posedge ref_clk);
      penable <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge ref_clk);
         if (pready === 1'b1) break;
      end
      if (k == 50) begin
         nMismatch++;
         print_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // wait for a byte at the fifo head, compare it and take it
   task automatic pop(input logic [7:0] exp);
      int k;
      for (k = 0; k < 100; k++) begin
         @(posedge ref_clk);
         if (rxValid === 1'b1) break;
      end
      if (k == 100) begin
         nMismatch++;
         print_verdict();
      end
      `CHK(rxData, exp)
      rxReady <= 1'b1;
      @(posedge ref_clk);
      rxReady <= 1'b0;
   endtask : pop

   // ==========================================================
   // main sequence
   initial begin
      {sys_rst, psel, penable, pwrite, rxReady, paddr, pwdata} = {1'b1, 68'h0};
      nMismatch = 0;
      numChecks = 0;
      repeat (20) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      `CHK({flashIoSupplyEn, controllerBypass, pready}, 3'b101)
      apb(fsc_pkg::ADDR_SUPPLY, 1'b0, 32'h0);
      `CHK(rd, 32'h0000_0001)
      apb(fsc_pkg::ADDR_BYPASS, 1'b0, 32'h0);
      `CHK(rd, 32'h0000_0000)
      apb(fsc_pkg::ADDR_FILL, 1'b0, 32'h0);
      `CHK(rd, 32'h0000_0000)
      apb(fsc_pkg::ADDR_STATE, 1'b0, 32'h0);
      `CHK({rd, err}, {32'h0000_1000, 1'b0})
      // table of fill settings, one byte frame each
      foreach (ROWS[i]) begin
         apb(fsc_pkg::ADDR_FILL, 1'b1, {16'h0, ROWS[i].fill});
         apb(fsc_pkg::ADDR_FILL, 1'b0, 32'h0);
         `CHK(rd, {16'h0, ROWS[i].fill & fsc_pkg::FILL_MASK})
         fm.frame_edge(1'b1);
         fm.send_byte(ROWS[i].miso, mo);
         fm.frame_edge(1'b0);
         `CHK(mo, ROWS[i].mosi)
         apb(fsc_pkg::ADDR_STATE, 1'b0, 32'h0);
         `CHK(rd, 32'h0000_1011)
         pop(ROWS[i].miso);
      end
      // supply switch off and back on, reserved bits read zero
      apb(fsc_pkg::ADDR_SUPPLY, 1'b1, 32'h0);
      apb(fsc_pkg::ADDR_SUPPLY, 1'b0, 32'h0);
      `CHK({rd, flashIoSupplyEn}, {32'h0, 1'b0})
      apb(fsc_pkg::ADDR_SUPPLY, 1'b1, 32'hffff_ffff);
      apb(fsc_pkg::ADDR_SUPPLY, 1'b0, 32'h0);
      `CHK({rd, flashIoSupplyEn}, {32'h1, 1'b1})
      // bypass: no fill on mosi and no byte received
      apb(fsc_pkg::ADDR_FILL, 1'b1, 32'h0000_ff08);
      apb(fsc_pkg::ADDR_BYPASS, 1'b1, 32'hffff_ffff);
      apb(fsc_pkg::ADDR_BYPASS, 1'b0, 32'h0);
      `CHK({rd, controllerBypass}, {32'h1, 1'b1})
      fm.frame_edge(1'b1);
      fm.send_byte(8'h99, mo);
      fm.frame_edge(1'b0);
      `CHK({mo, rxValid}, {8'h00, 1'b0})
      apb(fsc_pkg::ADDR_BYPASS, 1'b1, 32'h0);
      // refused accesses: write to the state register, unmapped read
      apb(fsc_pkg::ADDR_STATE, 1'b1, 32'hffff_ffff);
      `CHK(err, 1'b1)
      apb(fsc_pkg::ADDR_STATE, 1'b0, 32'h0);
      `CHK(rd, 32'h0000_1000)
      apb(32'h4001_2030, 1'b0, 32'h0);
      `CHK({rd, err}, {32'h0, 1'b1})
      // fill the fifo past full with the consumer stalled, then drain
      fm.frame_edge(1'b1);
      apb(fsc_pkg::ADDR_STATE, 1'b0, 32'h0);
      `CHK(rd, 32'h0000_0100)
      #37; // keep link edges off ref_clk edges
      for (int i = 0; i < 17; i++) begin
         fm.send_byte(8'h10 + 8'(i), mo);
         `CHK(mo, 8'hff)
      end
      apb(fsc_pkg::ADDR_STATE, 1'b0, 32'h0);
      `CHK(rd[10:4], 7'h22)
      for (int i = 0; i < 17; i++) begin
         pop(8'h10 + 8'(i));
      end
      apb(fsc_pkg::ADDR_STATE, 1'b0, 32'h0);
      `CHK({rxValid, rd[10:4]}, 8'h10)
      fm.frame_edge(1'b0);
      // mid-run reset brings back the reset values
      apb(fsc_pkg::ADDR_SUPPLY, 1'b1, 32'h0);
      sys_rst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      `CHK({flashIoSupplyEn, controllerBypass, rxValid}, 3'b100)
      apb(fsc_pkg::ADDR_FILL, 1'b0, 32'h0);
      `CHK(rd, 32'h0000_0000)
      print_verdict();
   end
endmodule : tb_serial_flash_txfill_status_power
